/* File: logic/dpd_packet_decoder.sv */
// link-layer packet decoder of the video-mode display driver
`timescale 1ns/1ps
// How it works
// RULE1: read request: type 06h, vc 0, second byte 0
// RULE2: after turnaround answer error report or data
// RULE3: null long packet payload is discarded
// RULE4: sync events decoded from upper type bits
// RULE5: vertical start and end imply horizontal start
// RULE6: host pairs sync start and end events
// RULE7: host may chain syncs with blanking
// RULE8: host bursts a line then low power
// RULE9: end packets detected in either link mode
// RULE10: end packet has one fixed form
// RULE11: end packet support can be switched off
// RULE12: no end packets sent in low power
// RULE13: colour on enters eight-colour mode
// RULE14: colour off restores normal display
// RULE15: blanking packets accepted, payload ignored
// RULE16: word count locates the long packet end
// RULE17: pixels unpack five red, six green, five blue
// RULE18: host line length is whole byte pairs
// RULE19: host feeds pixels fast, no frame store
// RULE20: host sets return size before reading
// RULE21: packets with errors are discarded; pixels of a packet with a checksum error are still output
// RULE22: every byte travels lsb first

module dpd_packet_decoder (
  // system clock side
  input wire logic clk,
  input wire logic rstn,
  input wire logic eot_en,
  // link byte clock side
  input wire logic lclk,
  input wire logic lrstn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_hs,
  input wire logic rx_frame,
  input wire logic rx_hdr_err,
  input wire logic rx_crc_err,
  input wire logic bta,
  // pixel stream, link clock
  output logic pix_valid,
  output dpd_pkg::dpd_pix_t pix,
  // turnaround answer, link clock
  output logic resp_valid,
  output logic resp_ack_err,
  // decoded events, system clock
  output dpd_pkg::dpd_sync_t sync_evt,
  output logic eot_evt,
  output logic blank_evt,
  output logic rd_evt,
  output logic [7:0] rd_cmd,
  output logic eight_colour
);

  //////////////////////////////////////////////////////////////////////////////
  // link domain state
  dpd_pkg::dpd_state_t st_q; // position in packet
  logic [5:0] dt_q; // data type
  logic [1:0] vc_q; // virtual channel
  logic [7:0] b1_q; // first byte after identifier
  logic [7:0] b2_q; // second byte after identifier
  logic [15:0] cnt_q; // payload bytes left
  logic drop_q; // packet carries a header error
  logic half_q; // second byte of a pixel pending
  logic [7:0] lo_q; // first pixel byte
  logic [dpd_pkg::EV_NUM-1:0] tog_q; // event toggles
  logic eight_q; // eight-colour mode, link side
  logic [7:0] cmd_q; // held read command
  logic err_seen_q; // error since last turnaround
  logic eot_s1_q; // enable synchroniser
  logic eot_s2_q;
  logic hdr_done; // header complete this byte
  logic hdr_ok; // header complete and clean
  logic is_long; // data type is a long packet
  logic eot_ok; // end packet of the fixed form

  // long types have bit 3 set and a non-zero low field
  assign is_long = dt_q[3] && (dt_q[2:0] != 3'h0);
  assign hdr_done = rx_valid && (st_q == dpd_pkg::DPD_ST_ECC);
  assign hdr_ok = hdr_done && !rx_hdr_err; // RULE21
  // fixed form of the end packet
  assign eot_ok = (vc_q == dpd_pkg::VC_ZERO) && (b1_q == dpd_pkg::EOT_PAYLOAD) &&
                  (b2_q == dpd_pkg::EOT_PAYLOAD) && (rx_byte == dpd_pkg::EOT_ECC); // RULE10

  //////////////////////////////////////////////////////////////////////////////
  // end packet enable crosses from the system clock
  always_ff @(posedge lclk) begin
    if (!lrstn) begin
      eot_s1_q <= 1'b0;
      eot_s2_q <= 1'b0;
    end else begin
      eot_s1_q <= eot_en;
      eot_s2_q <= eot_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // packet walk; bytes arrive deserialised, bit 0 first on the lane
  always_ff @(posedge lclk) begin
    if (!lrstn) begin
      st_q <= dpd_pkg::DPD_ST_DI;
      dt_q <= 6'h00;
      vc_q <= 2'h0;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      cnt_q <= 16'h0000;
      drop_q <= 1'b0;
    end else if (!rx_frame) begin
      // a frame that ends early abandons the packet
      st_q <= dpd_pkg::DPD_ST_DI;
      drop_q <= 1'b0;
    end else if (rx_valid) begin
      case (st_q)
        dpd_pkg::DPD_ST_DI: begin
          // identifier: channel in the top bits, type below
          vc_q <= rx_byte[7:6]; // RULE22
          dt_q <= rx_byte[5:0];
          st_q <= dpd_pkg::DPD_ST_B1;
        end
        dpd_pkg::DPD_ST_B1: begin
          b1_q <= rx_byte;
          st_q <= dpd_pkg::DPD_ST_B2;
        end
        dpd_pkg::DPD_ST_B2: begin
          b2_q <= rx_byte;
          st_q <= dpd_pkg::DPD_ST_ECC;
        end
        dpd_pkg::DPD_ST_ECC: begin
          drop_q <= rx_hdr_err;
          cnt_q <= {b2_q, b1_q}; // RULE16
          if (!is_long) begin
            st_q <= dpd_pkg::DPD_ST_DI;
          end else if ({b2_q, b1_q} == 16'h0000) begin
            st_q <= dpd_pkg::DPD_ST_CS0; // RULE16
          end else begin
            st_q <= dpd_pkg::DPD_ST_PAY;
          end
        end
        dpd_pkg::DPD_ST_PAY: begin
          // count payload down to the footer
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            st_q <= dpd_pkg::DPD_ST_CS0; // RULE16
          end
        end
        dpd_pkg::DPD_ST_CS0: begin
          st_q <= dpd_pkg::DPD_ST_CS1;
        end
        default: begin
          st_q <= dpd_pkg::DPD_ST_DI;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 16-bit pixel unpacking; null and blanking payloads are skipped by the pixel type check
  always_ff @(posedge lclk) begin
    if (!lrstn) begin
      half_q <= 1'b0;
      lo_q <= 8'h00;
      pix_valid <= 1'b0;
      pix <= '0;
    end else begin
      pix_valid <= 1'b0;
      if (st_q != dpd_pkg::DPD_ST_PAY) begin
        half_q <= 1'b0;
      end else if (rx_valid && !drop_q && dt_q == dpd_pkg::DT_PIX16) begin // RULE3 RULE15
        half_q <= !half_q;
        if (!half_q) begin
          lo_q <= rx_byte;
        end else begin
          // red low, green split over both bytes, blue high
          pix_valid <= 1'b1; // RULE17
          pix.red <= lo_q[4:0];
          pix.green <= {rx_byte[2:0], lo_q[7:5]};
          pix.blue <= rx_byte[7:3];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // packet actions; syncs, end packet, read and blanking flip toggles for the system clock, colour sets a level
  always_ff @(posedge lclk) begin
    if (!lrstn) begin
      tog_q <= '0;
      eight_q <= 1'b0;
      cmd_q <= 8'h00;
    end else begin
      if (hdr_ok && dt_q[3:0] == dpd_pkg::DT_SYNC_LO[3:0]) begin
        // upper type bits pick which sync event
        case (dt_q[5:4]) // RULE4
          2'b00: tog_q[dpd_pkg::EV_VS_START] <= !tog_q[dpd_pkg::EV_VS_START];
          2'b01: tog_q[dpd_pkg::EV_VS_END] <= !tog_q[dpd_pkg::EV_VS_END];
          2'b10: tog_q[dpd_pkg::EV_HS_START] <= !tog_q[dpd_pkg::EV_HS_START];
          default: tog_q[dpd_pkg::EV_HS_END] <= !tog_q[dpd_pkg::EV_HS_END];
        endcase
      end
      // end packet, link mode does not matter
      if (hdr_ok && eot_s2_q && dt_q == dpd_pkg::DT_EOT && eot_ok) begin // RULE9 RULE11
        tog_q[dpd_pkg::EV_EOT] <= !tog_q[dpd_pkg::EV_EOT];
      end
      if (hdr_ok && dt_q == dpd_pkg::DT_READ_NP && vc_q == dpd_pkg::VC_ZERO &&
          b2_q == dpd_pkg::READ_PARAM) begin // RULE1
        tog_q[dpd_pkg::EV_READ] <= !tog_q[dpd_pkg::EV_READ];
        cmd_q <= b1_q;
      end
      if (hdr_ok && dt_q == dpd_pkg::DT_COLOUR_ON) begin
        eight_q <= 1'b1; // RULE13
      end else if (hdr_ok && dt_q == dpd_pkg::DT_COLOUR_OFF) begin
        eight_q <= 1'b0; // RULE14
      end
      // blanking completes at its clean footer
      if (rx_valid && st_q == dpd_pkg::DPD_ST_CS1 && dt_q == dpd_pkg::DT_BLANK &&
          !drop_q && !rx_crc_err) begin // RULE15
        tog_q[dpd_pkg::EV_BLANK] <= !tog_q[dpd_pkg::EV_BLANK];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // turnaround answer: error report if the last packets failed
  // answers leave in low power, so no end packet ever follows them
  always_ff @(posedge lclk) begin
    if (!lrstn) begin
      err_seen_q <= 1'b0;
      resp_valid <= 1'b0;
      resp_ack_err <= 1'b0;
    end else begin
      resp_valid <= bta; // RULE2 RULE12
      resp_ack_err <= bta && err_seen_q;
      if (bta) begin
        err_seen_q <= 1'b0;
      end
      // a new error wins over the clear
      if ((hdr_done && rx_hdr_err) ||
          (rx_valid && st_q == dpd_pkg::DPD_ST_CS1 && rx_crc_err)) begin // RULE21
        err_seen_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system clock side: toggle synchronisers and event pulses
  logic [dpd_pkg::EV_NUM-1:0] s1_q; // first stage, read only by s2
  logic [dpd_pkg::EV_NUM-1:0] s2_q;
  logic [dpd_pkg::EV_NUM-1:0] s3_q; // edge reference
  logic [dpd_pkg::EV_NUM-1:0] ev; // one-cycle event strobes
  logic e1_q; // eight-colour level synchroniser
  logic e2_q;

  genvar gi;
  generate
    for (gi = 0; gi < dpd_pkg::EV_NUM; gi++) begin : g_sync
      // two flops then an edge reference per event
      always_ff @(posedge clk) begin
        if (!rstn) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= tog_q[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
      assign ev[gi] = s2_q[gi] ^ s3_q[gi];
    end
  endgenerate

  // registered event outputs; command is stable long before its strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_evt <= '0;
      eot_evt <= 1'b0;
      blank_evt <= 1'b0;
      rd_evt <= 1'b0;
      rd_cmd <= 8'h00;
      e1_q <= 1'b0;
      e2_q <= 1'b0;
      eight_colour <= 1'b0;
    end else begin
      sync_evt.vs_start <= ev[dpd_pkg::EV_VS_START];
      sync_evt.vs_end <= ev[dpd_pkg::EV_VS_END];
      // vertical start and end also open a line
      sync_evt.hs_start <= ev[dpd_pkg::EV_HS_START] | ev[dpd_pkg::EV_VS_START] |
                           ev[dpd_pkg::EV_VS_END]; // RULE5
      sync_evt.hs_end <= ev[dpd_pkg::EV_HS_END];
      eot_evt <= ev[dpd_pkg::EV_EOT];
      blank_evt <= ev[dpd_pkg::EV_BLANK];
      rd_evt <= ev[dpd_pkg::EV_READ];
      if (ev[dpd_pkg::EV_READ]) begin
        rd_cmd <= cmd_q;
      end
      e1_q <= eight_q;
      e2_q <= e1_q;
      eight_colour <= e2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_hdr_err;
    hdr_done && rx_hdr_err;
  endsequence
  property p_null_nopix;
    @(posedge lclk) disable iff (!lrstn)
      (st_q == dpd_pkg::DPD_ST_PAY && dt_q == dpd_pkg::DT_NULL_LONG) |=> !pix_valid;
  endproperty
  a_null_nopix: assert property (p_null_nopix) else $error("null payload made a pixel"); // RULE3
  property p_vs_hs;
    @(posedge clk) disable iff (!rstn)
      (sync_evt.vs_start || sync_evt.vs_end) |-> sync_evt.hs_start;
  endproperty
  a_vs_hs: assert property (p_vs_hs) else $error("vertical event lacks line start"); // RULE5
  property p_eot_off;
    @(posedge lclk) disable iff (!lrstn)
      (!eot_s2_q && hdr_done && dt_q == dpd_pkg::DT_EOT) |=> $stable(tog_q[dpd_pkg::EV_EOT]);
  endproperty
  a_eot_off: assert property (p_eot_off) else $error("end packet seen while disabled"); // RULE11
  // a clean end packet in low power still counts
  property p_eot_lp;
    @(posedge lclk) disable iff (!lrstn)
      (hdr_ok && !rx_hs && eot_s2_q && dt_q == dpd_pkg::DT_EOT && eot_ok) |=>
        $changed(tog_q[dpd_pkg::EV_EOT]);
  endproperty
  a_eot_lp: assert property (p_eot_lp) else $error("low-power end packet missed"); // RULE9
  property p_pix_fields;
    @(posedge lclk) disable iff (!lrstn)
      pix_valid |-> (pix.blue == $past(rx_byte[7:3])) && (pix.red == $past(lo_q[4:0]));
  endproperty
  a_pix_fields: assert property (p_pix_fields) else $error("pixel fields misplaced"); // RULE17
  property p_wc_zero;
    @(posedge lclk) disable iff (!lrstn)
      (hdr_done && rx_frame && is_long && {b2_q, b1_q} == 16'h0000) |=> st_q == dpd_pkg::DPD_ST_CS0;
  endproperty
  a_wc_zero: assert property (p_wc_zero) else $error("empty long packet not at footer"); // RULE16
  property p_err_drop;
    @(posedge lclk) disable iff (!lrstn)
      (s_hdr_err and (rx_frame && dt_q == dpd_pkg::DT_PIX16)) |=> (!pix_valid)[*3];
  endproperty
  a_err_drop: assert property (p_err_drop) else $error("bad packet produced pixels"); // RULE21
  // the first turnaround within 41 link cycles of a bad header reports it
  property p_resp;
    @(posedge lclk) disable iff (!lrstn)
      s_hdr_err ##1 first_match(##[0:40] bta) |=> resp_valid && resp_ack_err;
  endproperty
  a_resp: assert property (p_resp) else $error("error not reported at turnaround"); // RULE2
  property p_colour;
    @(posedge lclk) disable iff (!lrstn)
      (hdr_ok && dt_q == dpd_pkg::DT_COLOUR_ON) |=> eight_q [*2];
  endproperty
  a_colour: assert property (p_colour) else $error("eight-colour mode not entered"); // RULE13
  property p_read;
    @(posedge lclk) disable iff (!lrstn)
      (hdr_ok && dt_q == dpd_pkg::DT_READ_NP && vc_q == dpd_pkg::VC_ZERO &&
       b2_q == dpd_pkg::READ_PARAM) |=> (cmd_q == $past(b1_q)) && $changed(tog_q);
  endproperty
  a_read: assert property (p_read) else $error("read request not captured"); // RULE1

endmodule

/* File: logic/dpd_pkg.sv */
// shared constants and types of the display packet decoder
package dpd_pkg;
  // data identifier fields
  localparam logic [5:0] DT_SYNC_LO = 6'h01; // low nibble of all sync events
  localparam logic [5:0] DT_VS_START = 6'h01;
  localparam logic [5:0] DT_VS_END = 6'h11;
  localparam logic [5:0] DT_HS_START = 6'h21;
  localparam logic [5:0] DT_HS_END = 6'h31;
  localparam logic [5:0] DT_READ_NP = 6'h06; // read, no parameter
  localparam logic [5:0] DT_NULL_LONG = 6'h09;
  localparam logic [5:0] DT_EOT = 6'h08;
  localparam logic [5:0] DT_COLOUR_ON = 6'h12;
  localparam logic [5:0] DT_COLOUR_OFF = 6'h02;
  localparam logic [5:0] DT_BLANK = 6'h19;
  localparam logic [5:0] DT_PIX16 = 6'h0e;
  localparam logic [1:0] VC_ZERO = 2'h0;
  localparam logic [7:0] EOT_PAYLOAD = 8'h0f; // both payload bytes
  localparam logic [7:0] EOT_ECC = 8'h01;
  localparam logic [7:0] READ_PARAM = 8'h00;
  // event toggle slots crossing to the system clock
  localparam int EV_VS_START = 0;
  localparam int EV_VS_END = 1;
  localparam int EV_HS_START = 2;
  localparam int EV_HS_END = 3;
  localparam int EV_EOT = 4;
  localparam int EV_BLANK = 5;
  localparam int EV_READ = 6;
  localparam int EV_NUM = 7;
  // parser position within a packet
  typedef enum logic [2:0] {
    DPD_ST_DI = 3'b000,
    DPD_ST_B1 = 3'b001,
    DPD_ST_B2 = 3'b010,
    DPD_ST_ECC = 3'b011,
    DPD_ST_PAY = 3'b100,
    DPD_ST_CS0 = 3'b101,
    DPD_ST_CS1 = 3'b110
  } dpd_state_t;
  // sync events as seen by the timing logic
  typedef struct packed {
    logic vs_start;
    logic vs_end;
    logic hs_start;
    logic hs_end;
  } dpd_sync_t;
  // one unpacked 16-bit pixel
  typedef struct packed {
    logic [4:0] red;
    logic [5:0] green;
    logic [4:0] blue;
  } dpd_pix_t;
endpackage

/* File: testbench/dpd_host_model.sv */
// host-side link model that drives packet bytes into the decoder
`timescale 1ns/1ps
module dpd_host_model (
  // link byte clock
  input wire logic lclk,
  // received byte stream toward the decoder
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_hs,
  output logic rx_frame,
  output logic rx_hdr_err,
  output logic rx_crc_err,
  output logic bta
);
  logic [7:0] last_q; // last byte put on the lane

  // idle lane: no frame, data shows the inverse of the last byte
  initial begin
    last_q = 8'h00;
    rx_valid = 1'b0;
    rx_byte = 8'hff;
    rx_hs = 1'b0;
    rx_frame = 1'b0;
    rx_hdr_err = 1'b0;
    rx_crc_err = 1'b0;
    bta = 1'b0;
  end

  // one byte per link cycle, bit 0 is the first bit on the lane
  task put(input logic [7:0] b, input logic he, input logic ce);
    @(negedge lclk);
    rx_valid = 1'b1;
    rx_byte = b;
    rx_hdr_err = he;
    rx_crc_err = ce;
    last_q = b;
  endtask

  // open a transmission in the chosen link mode
  task frame_on(input logic hs);
    @(negedge lclk);
    rx_frame = 1'b1;
    rx_hs = hs;
  endtask

  // close the transmission and release the lane
  task frame_off();
    @(negedge lclk);
    rx_valid = 1'b0;
    rx_frame = 1'b0;
    rx_hdr_err = 1'b0;
    rx_crc_err = 1'b0;
    rx_byte = ~last_q;
  endtask

  // short packet: identifier, two data bytes, check byte
  task send_short(input logic [7:0] di, d0, d1, ecc, input logic he, hs);
    frame_on(hs);
    put(di, 1'b0, 1'b0);
    put(d0, 1'b0, 1'b0);
    put(d1, 1'b0, 1'b0);
    put(ecc, he, 1'b0);
    frame_off();
  endtask

  // long packet: header, word-count payload bytes up to eight, checksum
  task send_long(input logic [7:0] di, input logic [15:0] wc, input logic [7:0] pl [0:7],
                 input logic he, ce);
    frame_on(1'b1);
    put(di, 1'b0, 1'b0);
    put(wc[7:0], 1'b0, 1'b0);
    put(wc[15:8], 1'b0, 1'b0);
    put(8'h00, he, 1'b0);
    for (int i = 0; i < int'(wc) && i < 8; i++) begin
      put(pl[i], 1'b0, 1'b0);
    end
    put(8'h00, 1'b0, 1'b0);
    put(8'h00, 1'b0, ce);
    frame_off();
  endtask

  // hand the bus over to the display side
  task turn();
    @(negedge lclk);
    bta = 1'b1;
    @(negedge lclk);
    bta = 1'b0;
  endtask
endmodule

/* File: testbench/dpd_packet_decoder_test.sv */
// self-checking bench of the display packet decoder
`timescale 1ns/1ps
module dpd_packet_decoder_test;
  // clocks, resets and controls
  logic clk, rstn, lclk, lrstn, eot_en;
  // link signals from the host model
  logic rx_valid, rx_hs, rx_frame, rx_hdr_err, rx_crc_err, bta;
  logic [7:0] rx_byte;
  // decoder outputs
  logic pix_valid, resp_valid, resp_ack_err, eot_evt, blank_evt, rd_evt, eight_colour;
  logic [7:0] rd_cmd;
  dpd_pkg::dpd_pix_t pix;
  dpd_pkg::dpd_sync_t sync_evt;
  // scoreboard state
  int failures, samples_checked, pix_n, resp_n;
  logic cap_eot, cap_blank, cap_rd, resp_err;
  dpd_pkg::dpd_sync_t cap_sync;
  dpd_pkg::dpd_pix_t pix_log [0:3];
  logic [7:0] pl [0:7];

  dpd_packet_decoder dpd_packet_decoder_i (.clk, .rstn, .eot_en, .lclk, .lrstn, .rx_valid,
    .rx_byte, .rx_hs, .rx_frame, .rx_hdr_err, .rx_crc_err, .bta, .pix_valid, .pix,
    .resp_valid, .resp_ack_err, .sync_evt, .eot_evt, .blank_evt, .rd_evt, .rd_cmd,
    .eight_colour);
  dpd_host_model dpd_host_model_i (.lclk, .rx_valid, .rx_byte, .rx_hs, .rx_frame,
    .rx_hdr_err, .rx_crc_err, .bta);

  // system clock 5 ns, link clock 6 ns with an odd phase
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #1.3;
    forever #3 lclk = ~lclk;
  end

  // gather system-clock pulses between checks, mid-cycle away from the launching edge
  always @(negedge clk) begin
    cap_sync <= cap_sync | sync_evt;
    cap_eot <= cap_eot | eot_evt;
    cap_blank <= cap_blank | blank_evt;
    cap_rd <= cap_rd | rd_evt;
  end

  // log pixels and turnaround answers mid-cycle of the link clock
  always @(negedge lclk) begin
    if (pix_valid === 1'b1 && pix_n < 4) begin
      pix_log[pix_n] = pix;
      pix_n = pix_n + 1;
    end
    if (resp_valid === 1'b1) begin
      resp_err = resp_ack_err;
      resp_n = resp_n + 1;
    end
  end

  // report counts and verdict, then stop
  task wrap_up();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one comparison
  task check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask

  // forget captured activity; rising edge so the falling-edge capture cannot race it
  task clr();
    @(posedge clk);
    cap_sync = '0;
    {cap_eot, cap_blank, cap_rd} = 3'b000;
    pix_n = 0;
    resp_n = 0;
  endtask

  // packet wrappers that let the crossing land
  task sp(input logic [7:0] di, d0, d1, ecc, input logic he, input logic hs = 1'b1);
    dpd_host_model_i.send_short(di, d0, d1, ecc, he, hs);
    repeat (30) @(negedge clk);
  endtask
  task lp(input logic [7:0] di, input logic [15:0] wc, input logic he, ce);
    dpd_host_model_i.send_long(di, wc, pl, he, ce);
    repeat (30) @(negedge clk);
  endtask
  task tt();
    dpd_host_model_i.turn();
    repeat (4) @(negedge lclk);
  endtask

  // expected pixel from a byte pair
  function automatic dpd_pkg::dpd_pix_t px(input logic [7:0] a, b);
    return {a[4:0], b[2:0], a[7:5], b[7:3]};
  endfunction

  // colour mode on and off, refused on header error
  task t_colour();
    sp(8'h12, 8'h00, 8'h00, 8'h00, 1'b1);
    check(eight_colour === 1'b0, "colour on taken despite error");
    sp(8'h12, 8'h00, 8'h00, 8'h00, 1'b0);
    check(eight_colour === 1'b1, "colour on missed");
    // a cut frame must not let the next byte finish a colour-off header
    dpd_host_model_i.frame_on(1'b1);
    dpd_host_model_i.put(8'h02, 1'b0, 1'b0);
    dpd_host_model_i.put(8'h00, 1'b0, 1'b0);
    dpd_host_model_i.put(8'h00, 1'b0, 1'b0);
    dpd_host_model_i.frame_off();
    sp(8'h21, 8'h00, 8'h00, 8'h00, 1'b0);
    check(eight_colour === 1'b1, "cut frame completed a header");
    sp(8'h02, 8'h00, 8'h00, 8'h00, 1'b0);
    check(eight_colour === 1'b0, "colour off missed");
  endtask

  // all four sync events, vertical ones imply a horizontal start
  task t_sync();
    dpd_pkg::dpd_sync_t exp;
    for (int k = 0; k < 4; k++) begin
      clr();
      exp = {k == 0, k == 1, k < 3, k == 3};
      sp({2'b00, k[1:0], 4'h1}, 8'h00, 8'h00, 8'h00, 1'b0);
      check(cap_sync === exp, "sync event decode");
    end
    clr();
    sp(8'h21, 8'h00, 8'h00, 8'h00, 1'b1);
    check(cap_sync === 4'h0, "sync taken despite error");
  endtask

  // one end-packet case
  task eot_case(input logic hs, en, input logic [7:0] di, p1, ecc, input logic exp);
    @(negedge clk);
    eot_en = en;
    repeat (10) @(negedge clk);
    clr();
    sp(di, 8'h0f, p1, ecc, 1'b0, hs);
    check(cap_eot === exp, "end packet handling");
  endtask

  // end packets in both modes, enable switch and fixed form
  task t_eot();
    eot_case(1'b1, 1'b1, 8'h08, 8'h0f, 8'h01, 1'b1);
    eot_case(1'b0, 1'b1, 8'h08, 8'h0f, 8'h01, 1'b1);
    eot_case(1'b1, 1'b0, 8'h08, 8'h0f, 8'h01, 1'b0);
    eot_case(1'b1, 1'b1, 8'h48, 8'h0f, 8'h01, 1'b0);
    eot_case(1'b1, 1'b1, 8'h08, 8'h0e, 8'h01, 1'b0);
    eot_case(1'b1, 1'b1, 8'h08, 8'h0f, 8'h02, 1'b0);
    eot_en = 1'b1;
  endtask

  // read requests and answers after turnaround
  task t_read();
    tt();
    sp(8'h37, 8'h01, 8'h00, 8'h00, 1'b0);
    clr();
    sp(8'h06, 8'hda, 8'h00, 8'h00, 1'b0);
    check(cap_rd === 1'b1 && rd_cmd === 8'hda, "read request missed");
    clr();
    sp(8'h06, 8'h5a, 8'h01, 8'h00, 1'b0);
    sp(8'h46, 8'h5a, 8'h00, 8'h00, 1'b0);
    check(cap_rd === 1'b0 && rd_cmd === 8'hda, "bad read request taken");
    tt();
    check(resp_n == 1 && resp_err === 1'b0, "answer should carry data");
    sp(8'h12, 8'h00, 8'h00, 8'h00, 1'b1);
    tt();
    check(resp_n == 2 && resp_err === 1'b1, "answer should report error");
  endtask

  // null, blanking and pixel long packets
  task t_long();
    pl = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h89, 8'h23, 8'h12, 8'ha2};
    clr();
    lp(8'h09, 16'h0008, 1'b0, 1'b0);
    check(cap_blank === 1'b0 && pix_n == 0, "null payload acted on");
    check(eight_colour === 1'b0, "payload byte parsed as header");
    clr();
    lp(8'h19, 16'h0006, 1'b0, 1'b0);
    check(cap_blank === 1'b1 && pix_n == 0, "blanking packet missed");
    clr();
    lp(8'h19, 16'h0003, 1'b1, 1'b0);
    check(cap_blank === 1'b0, "blanking taken despite error");
    clr();
    lp(8'h19, 16'h0000, 1'b0, 1'b0);
    check(cap_blank === 1'b1, "empty blanking packet missed");
    clr();
    lp(8'h0e, 16'h0004, 1'b1, 1'b0);
    check(pix_n == 0, "pixels from a bad header");
    clr();
    lp(8'h0e, 16'h0004, 1'b0, 1'b0);
    check(pix_n == 2, "pixel count");
    check(pix_log[0] === px(pl[0], pl[1]), "first pixel");
    check(pix_log[1] === px(pl[2], pl[3]), "second pixel");
    tt();
    lp(8'h19, 16'h0002, 1'b0, 1'b1);
    tt();
    check(resp_err === 1'b1, "checksum error not reported");
  endtask

  // cut a hang short
  initial begin
    #60us;
    failures++;
    $display("ERROR %0t: run did not finish", $time);
    wrap_up();
  end

  // reset, then the scenarios
  initial begin
    rstn = 1'b0;
    lrstn = 1'b0;
    eot_en = 1'b1;
    failures = 0;
    samples_checked = 0;
    cap_sync = '0;
    {cap_eot, cap_blank, cap_rd, resp_err} = 4'h0;
    pix_n = 0;
    resp_n = 0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    lrstn = 1'b1;
    repeat (4) @(negedge clk);
    t_colour();
    t_sync();
    t_eot();
    t_read();
    t_long();
    wrap_up();
  end
endmodule
